// file: sfl_pkg.sv
// shared constants and types for the spi status flag block
`default_nettype none

package sfl_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h64;
    localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 8'h70;

    // status field positions
    localparam int unsigned RX_EMPTY_BIT       = 0;
    localparam int unsigned RX_FULL_BIT        = 1;
    localparam int unsigned TX_EMPTY_BIT       = 2;
    localparam int unsigned TX_FULL_BIT        = 3;
    localparam int unsigned MODE_FAULT_BIT     = 4;
    localparam int unsigned SLAVE_SEL_BIT      = 5;
    localparam int unsigned CLOCK_MODE_ERR_BIT = 6;
    localparam int unsigned STATUS_W           = 7;

    // status reset values
    localparam logic RX_EMPTY_RESET       = 1'b1;
    localparam logic RX_FULL_RESET        = 1'b0;
    localparam logic TX_EMPTY_RESET       = 1'b1;
    localparam logic TX_FULL_RESET        = 1'b0;
    localparam logic MODE_FAULT_RESET     = 1'b0;
    localparam logic SLAVE_SEL_RESET      = 1'b1;
    localparam logic CLOCK_MODE_ERR_RESET = 1'b0;

    // configuration register layout: bit 0 master, 1 cpha, 2 cpol
    localparam int unsigned CFG_W = 3;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

    // fifo depths the logic can serve
    localparam int unsigned FIFO_DEPTH_NONE  = 0;
    localparam int unsigned FIFO_DEPTH_SMALL = 16;
    localparam int unsigned FIFO_DEPTH_LARGE = 256;

    typedef enum {
        SFL_STD,
        SFL_DUAL,
        SFL_QUAD
    } sfl_spi_mode_t;

    typedef struct packed {
        logic cpol;
        logic cpha;
        logic master;
    } sfl_cfg_t;

    // one-cycle events and levels from the rest of the controller
    typedef struct packed {
        logic tx_write;
        logic rx_read;
        logic xfer_done;
        logic ss_active;
    } sfl_core_evt_t;

endpackage

`default_nettype wire

// file: sfl_occ_cnt.sv
// fifo occupancy counter with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none

module sfl_occ_cnt #(
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // occupancy events
    input  wire logic inc_in,
    input  wire logic dec_in,
    // flags
    output var  logic full_out,
    output var  logic empty_out
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] ONE_CNT  = CNT_W'(1);
    localparam logic [CNT_W-1:0] ZERO_CNT = '0;

    // a zero depth leaves the counter without bits
    if (DEPTH < 1) begin : g_bad_depth
        $error("occupancy depth must be at least 1");
    end

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             do_inc;
    logic             do_dec;

    // overflow and underflow are dropped, the host side reports them
    assign do_inc = inc_in && (count_q != FULL_CNT || dec_in);
    assign do_dec = dec_in && (count_q != ZERO_CNT || inc_in);

    always_comb begin
        count_d = count_q;
        if (do_inc && !do_dec) begin
            count_d = count_q + ONE_CNT;
        end else if (do_dec && !do_inc) begin
            count_d = count_q - ONE_CNT;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q   <= ZERO_CNT;
            full_out  <= 1'b0;
            empty_out <= 1'b1;
        end else begin
            count_q   <= count_d;
            full_out  <= (count_d == FULL_CNT);
            empty_out <= (count_d == ZERO_CNT);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    AST_FULL_AT_DEPTH: assert property (
        @(posedge clk_in) disable iff (rst_in)
        full_out == (count_q == FULL_CNT))
        else $error("full flag does not match occupancy at depth");

    AST_EMPTY_AT_ZERO: assert property (
        @(posedge clk_in) disable iff (rst_in)
        empty_out == (count_q == ZERO_CNT))
        else $error("empty flag does not match zero occupancy");

    AST_COUNT_STEP: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (dec_in && !inc_in && count_q != ZERO_CNT)
        |=> count_q == $past(count_q) - ONE_CNT)
        else $error("occupancy did not step down by one");

endmodule

`default_nettype wire

// file: sfl_status_top.sv
// spi status flag logic with its apb register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - wide mode with flash supported, cpol xor cpha sets clock error
// - slave select flag 1, 0 when selected
// - slave select flag follows chip select one cycle later
// - select going active while master sets mode fault
// - reading status clears mode fault
// - one-cycle strobe on mode fault rise
// - fifo tx full while fifo at depth
// - no fifo: write sets, transfer clears tx full
// - fifo tx empty as soon as fifo drains
// - tx occupancy drops on transfer completion
// - no fifo: host write clears tx empty, transfer sets
// - rx full at depth, transfers increment occupancy
// - no fifo: transfer sets rx full, complements
// - rx empty at zero, host reads decrement
// - no fifo: read sets, transfer clears rx empty
// - wide modes always have fifos
// - slave select flag reads 1 after reset
module sfl_status_top
    import sfl_pkg::*;
#(
    parameter sfl_spi_mode_t SPI_MODE        = SFL_STD,
    parameter int unsigned   FIFO_DEPTH      = FIFO_DEPTH_SMALL,
    parameter bit            FLASH_SUPPORTED = 1'b1
) (
    // clock and reset
    input  wire logic                SYS_CLK_IN,
    input  wire logic                RESET_IN,
    // apb slave
    input  wire logic                PSEL_IN,
    input  wire logic                PENABLE_IN,
    input  wire logic                PWRITE_IN,
    input  wire logic [ADDR_W-1:0]   PADDR_IN,
    input  wire logic [DATA_W-1:0]   PWDATA_IN,
    output var  logic [DATA_W-1:0]   PRDATA_OUT,
    output var  logic                PREADY_OUT,
    output var  logic                PSLVERR_OUT,
    // controller events
    input  wire sfl_core_evt_t       CORE_EVT_IN,
    // flags and configuration towards the controller
    output var  logic [STATUS_W-1:0] STATUS_FLAGS_OUT,
    output var  sfl_cfg_t            CONFIG_OUT,
    output var  logic                MODE_FAULT_STROBE_OUT
);

    localparam bit WIDE     = (SPI_MODE != SFL_STD);
    localparam bit HAS_FIFO = (FIFO_DEPTH != FIFO_DEPTH_NONE);
    localparam int unsigned PAD_W = DATA_W - STATUS_W;
    localparam int unsigned CPAD_W = DATA_W - CFG_W;

    // elaboration guard on configuration
    if (!(FIFO_DEPTH == FIFO_DEPTH_NONE || FIFO_DEPTH == FIFO_DEPTH_SMALL
          || FIFO_DEPTH == FIFO_DEPTH_LARGE)) begin : g_bad_depth
        $error("fifo depth must be 0, 16 or 256");
    end
    if (WIDE && !HAS_FIFO) begin : g_bad_wide
        $error("dual and quad modes need fifos");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic     apb_setup;
    logic     apb_done;
    logic     addr_status;
    logic     addr_config;
    logic     rd_status_q;
    sfl_cfg_t cfg_q;

    assign apb_setup   = PSEL_IN && !PENABLE_IN;
    assign apb_done    = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign addr_status = (PADDR_IN == STATUS_OFFSET);
    assign addr_config = (PADDR_IN == CONFIG_OFFSET);

    // flags
    logic                clk_err_q;
    logic                slave_sel_q;
    logic                mode_fault_flag_q;
    logic                mode_fault_flag_d;
    logic                tx_full;
    logic                tx_empty;
    logic                rx_full;
    logic                rx_empty;
    logic [STATUS_W-1:0] status_word;

    always_comb begin
        status_word                     = '0;
        status_word[CLOCK_MODE_ERR_BIT] = clk_err_q;
        status_word[SLAVE_SEL_BIT]      = slave_sel_q;
        status_word[MODE_FAULT_BIT]     = mode_fault_flag_q;
        status_word[TX_FULL_BIT]        = tx_full;
        status_word[TX_EMPTY_BIT]       = tx_empty;
        status_word[RX_FULL_BIT]        = rx_full;
        status_word[RX_EMPTY_BIT]       = rx_empty;
    end

    // zero wait: ready in the first access cycle
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PREADY_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= apb_setup;
        end
    end

    // read data latched in setup so the access edge sees a stable word
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT  <= '0;
            PSLVERR_OUT <= 1'b0;
            rd_status_q <= 1'b0;
        end else if (apb_setup) begin
            PSLVERR_OUT <= !(addr_status || addr_config);
            rd_status_q <= addr_status && !PWRITE_IN;
            if (PWRITE_IN) begin
                PRDATA_OUT <= '0;
            end else if (addr_status) begin
                PRDATA_OUT <= {{PAD_W{1'b0}}, status_word};
            end else if (addr_config) begin
                PRDATA_OUT <= {{CPAD_W{1'b0}}, cfg_q};
            end else begin
                PRDATA_OUT <= '0;
            end
        end
    end

    // only the configuration register takes writes
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            cfg_q <= CFG_RESET;
        end else if (apb_done && PWRITE_IN && addr_config) begin
            cfg_q <= sfl_cfg_t'(PWDATA_IN[CFG_W-1:0]);
        end
    end

    assign CONFIG_OUT = cfg_q;

    ////////////////////////////////////////////////////////////////////////
    // clock mode error and slave selection

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            clk_err_q <= CLOCK_MODE_ERR_RESET;
        end else begin
            clk_err_q <= WIDE && FLASH_SUPPORTED
                         && (cfg_q.cpol ^ cfg_q.cpha);
        end
    end

    // low while an external master selects us as slave
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            slave_sel_q <= SLAVE_SEL_RESET;
        end else begin
            slave_sel_q <= !(!cfg_q.master
                             && CORE_EVT_IN.ss_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode fault

    logic ss_prev_q;
    logic mode_fault_flag_set;
    logic mode_fault_flag_clr;

    assign mode_fault_flag_set = CORE_EVT_IN.ss_active && !ss_prev_q && cfg_q.master;
    // clear only a fault software actually saw, so a late one survives
    assign mode_fault_flag_clr = apb_done && !PWRITE_IN && rd_status_q
                      && PRDATA_OUT[MODE_FAULT_BIT];
    assign mode_fault_flag_d   = mode_fault_flag_set || (mode_fault_flag_q && !mode_fault_flag_clr);

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ss_prev_q <= 1'b0;
        end else begin
            ss_prev_q <= CORE_EVT_IN.ss_active;
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            mode_fault_flag_q <= MODE_FAULT_RESET;
        end else begin
            mode_fault_flag_q <= mode_fault_flag_d;
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            MODE_FAULT_STROBE_OUT <= 1'b0;
        end else begin
            MODE_FAULT_STROBE_OUT <= mode_fault_flag_d && !mode_fault_flag_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit and receive flags

    if (HAS_FIFO) begin : g_fifo
        logic [1:0] inc_vec;
        logic [1:0] dec_vec;
        logic [1:0] full_vec;
        logic [1:0] empty_vec;

        // channel 0 transmit, channel 1 receive
        assign inc_vec[0] = CORE_EVT_IN.tx_write;
        assign dec_vec[0] = CORE_EVT_IN.xfer_done;
        assign inc_vec[1] = CORE_EVT_IN.xfer_done;
        assign dec_vec[1] = CORE_EVT_IN.rx_read;

        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            sfl_occ_cnt #(
                .DEPTH (FIFO_DEPTH)
            ) u_occ (
                .clk_in    (SYS_CLK_IN),
                .rst_in    (RESET_IN),
                .inc_in    (inc_vec[ch]),
                .dec_in    (dec_vec[ch]),
                .full_out  (full_vec[ch]),
                .empty_out (empty_vec[ch])
            );
        end

        assign tx_full  = full_vec[0];
        assign tx_empty = empty_vec[0];
        assign rx_full  = full_vec[1];
        assign rx_empty = empty_vec[1];
    end else begin : g_nofifo
        logic tx_full_q;
        logic tx_empty_q;
        logic rx_full_q;
        logic rx_empty_q;

        // a write in the completing cycle leaves a word pending
        always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
            if (RESET_IN) begin
                tx_full_q  <= TX_FULL_RESET;
                tx_empty_q <= TX_EMPTY_RESET;
            end else if (CORE_EVT_IN.tx_write) begin
                tx_full_q  <= 1'b1;
                tx_empty_q <= 1'b0;
            end else if (CORE_EVT_IN.xfer_done) begin
                tx_full_q  <= 1'b0;
                tx_empty_q <= 1'b1;
            end
        end

        // new data beats a read in the same cycle
        always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
            if (RESET_IN) begin
                rx_full_q  <= RX_FULL_RESET;
                rx_empty_q <= RX_EMPTY_RESET;
            end else if (CORE_EVT_IN.xfer_done) begin
                rx_full_q  <= 1'b1;
                rx_empty_q <= 1'b0;
            end else if (CORE_EVT_IN.rx_read) begin
                rx_full_q  <= 1'b0;
                rx_empty_q <= 1'b1;
            end
        end

        assign tx_full  = tx_full_q;
        assign tx_empty = tx_empty_q;
        assign rx_full  = rx_full_q;
        assign rx_empty = rx_empty_q;
    end

    assign STATUS_FLAGS_OUT = status_word;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    sequence s_mode_fault_flag_cause;
        CORE_EVT_IN.ss_active && !ss_prev_q && cfg_q.master;
    endsequence

    sequence s_strobe_pulse;
        MODE_FAULT_STROBE_OUT ##1 !MODE_FAULT_STROBE_OUT;
    endsequence

    sequence s_status_read_fault;
        apb_done && !PWRITE_IN && rd_status_q && PRDATA_OUT[MODE_FAULT_BIT];
    endsequence

    AST_CLK_MODE_ERR: assert property (
        ##1 clk_err_q == (WIDE && FLASH_SUPPORTED
                          && ($past(cfg_q.cpol) ^ $past(cfg_q.cpha))))
        else $error("clock mode error flag wrong");

    AST_SLAVE_SELECTED: assert property (
        (!cfg_q.master && CORE_EVT_IN.ss_active) |=> !slave_sel_q)
        else $error("slave select flag not low when selected");

    AST_SLAVE_IDLE: assert property (
        (cfg_q.master || !CORE_EVT_IN.ss_active) |=> slave_sel_q)
        else $error("slave select flag low while not selected");

    AST_MODE_FAULT_FLAG_SET: assert property (
        s_mode_fault_flag_cause |=> mode_fault_flag_q ##1 (mode_fault_flag_q || $past(mode_fault_flag_clr)))
        else $error("mode fault not raised on select as master");

    AST_MODE_FAULT_FLAG_CLEAR: assert property (
        (s_status_read_fault ##0 !mode_fault_flag_set) |=> !mode_fault_flag_q)
        else $error("mode fault not cleared by status read");

    AST_MODE_FAULT_FLAG_STROBE: assert property (
        (mode_fault_flag_d && !mode_fault_flag_q) |=> s_strobe_pulse)
        else $error("mode fault strobe not a single cycle");

    AST_STROBE_CAUSE: assert property (
        MODE_FAULT_STROBE_OUT |-> $rose(mode_fault_flag_q))
        else $error("strobe without mode fault rise");

    AST_TX_WRITE: assert property (
        (CORE_EVT_IN.tx_write && (!HAS_FIFO || !tx_full)) |=> !tx_empty)
        else $error("transmit empty not cleared by host write");

    AST_TX_NOFIFO: assert property (
        (!HAS_FIFO && CORE_EVT_IN.xfer_done && !CORE_EVT_IN.tx_write)
        |=> !tx_full && tx_empty)
        else $error("no fifo transmit flags wrong after transfer");

    AST_RX_COMPLEMENT: assert property (
        !HAS_FIFO |-> (rx_full == !rx_empty))
        else $error("receive full and empty not complements");

    AST_RX_READ: assert property (
        (!HAS_FIFO && CORE_EVT_IN.rx_read && !CORE_EVT_IN.xfer_done)
        |=> rx_empty)
        else $error("receive empty not set by host read");

    AST_RX_DONE: assert property (
        CORE_EVT_IN.xfer_done && !CORE_EVT_IN.rx_read |=> !rx_empty)
        else $error("receive empty after completed transfer");

    AST_RESERVED_ZERO: assert property (
        (apb_setup && addr_status && !PWRITE_IN)
        |=> PRDATA_OUT[DATA_W-1:STATUS_W] == '0)
        else $error("reserved status bits not zero");

    AST_STATUS_WRITE: assert property (
        (apb_done && PWRITE_IN && addr_status)
        |=> $stable(cfg_q) && (mode_fault_flag_q || !$past(mode_fault_flag_q)))
        else $error("status write changed configuration or fault");

endmodule

`default_nettype wire

// file: sfl_status_top_tb.sv
// self-checking testbench for the spi status flag block
`timescale 1ns/1ps
`default_nettype none

module sfl_status_top_tb;
    import sfl_pkg::*;

    logic                SYS_CLK_IN;
    logic                RESET_IN;
    logic                psel;
    logic                pen;
    logic                pwr;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   rd_a;
    logic [DATA_W-1:0]   rd_b;
    logic                rdy_a;
    logic                rdy_b;
    logic                err_a;
    logic                err_b;
    logic                stb_a;
    logic                stb_b;
    logic [STATUS_W-1:0] st_a;
    logic [STATUS_W-1:0] st_b;
    sfl_cfg_t            cfg_a;
    sfl_cfg_t            cfg_b;
    sfl_core_evt_t       evt;
    logic [DATA_W-1:0]   got_a;
    logic [DATA_W-1:0]   got_b;
    logic                got_err;
    int                  n_mismatch;
    int                  cmp_count;

    ////////////////////////////////////////////////////////////////////////
    // wide mode with fifos beside a standard mode without fifos;
    // both share the bus and the controller events
    sfl_status_top #(
        .SPI_MODE        (SFL_DUAL),
        .FIFO_DEPTH      (FIFO_DEPTH_SMALL),
        .FLASH_SUPPORTED (1'b1)
    ) u_sfl_status_top (
        .SYS_CLK_IN            (SYS_CLK_IN),
        .RESET_IN              (RESET_IN),
        .PSEL_IN               (psel),
        .PENABLE_IN            (pen),
        .PWRITE_IN             (pwr),
        .PADDR_IN              (paddr),
        .PWDATA_IN             (pwdata),
        .PRDATA_OUT            (rd_a),
        .PREADY_OUT            (rdy_a),
        .PSLVERR_OUT           (err_a),
        .CORE_EVT_IN           (evt),
        .STATUS_FLAGS_OUT      (st_a),
        .CONFIG_OUT            (cfg_a),
        .MODE_FAULT_STROBE_OUT (stb_a)
    );

    sfl_status_top #(
        .SPI_MODE        (SFL_STD),
        .FIFO_DEPTH      (FIFO_DEPTH_NONE),
        .FLASH_SUPPORTED (1'b1)
    ) u_sfl_status_top_nf (
        .SYS_CLK_IN            (SYS_CLK_IN),
        .RESET_IN              (RESET_IN),
        .PSEL_IN               (psel),
        .PENABLE_IN            (pen),
        .PWRITE_IN             (pwr),
        .PADDR_IN              (paddr),
        .PWDATA_IN             (pwdata),
        .PRDATA_OUT            (rd_b),
        .PREADY_OUT            (rdy_b),
        .PSLVERR_OUT           (err_b),
        .CORE_EVT_IN           (evt),
        .STATUS_FLAGS_OUT      (st_b),
        .CONFIG_OUT            (cfg_b),
        .MODE_FAULT_STROBE_OUT (stb_b)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #20 SYS_CLK_IN = ~SYS_CLK_IN;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // read data is taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK_IN);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge SYS_CLK_IN);
        pen <= 1'b1;
        do begin
            @(posedge SYS_CLK_IN);
            n++;
        end while (rdy_a !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            $display("unexpected bus wait: expected ready, seen none");
        end
        chk("plain ready", 32'h1, {31'h0, rdy_b});
        got_a   = rd_a;
        got_b   = rd_b;
        got_err = err_a;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK_IN);
        #1;
    endtask

    // k = {tx_write, rx_read, xfer_done}, held for n sampling edges
    task automatic pulse(input logic [2:0] k, input int n);
        @(posedge SYS_CLK_IN);
        evt.tx_write  <= k[2];
        evt.rx_read   <= k[1];
        evt.xfer_done <= k[0];
        repeat (n) @(posedge SYS_CLK_IN);
        evt.tx_write  <= 1'b0;
        evt.rx_read   <= 1'b0;
        evt.xfer_done <= 1'b0;
        tick(1);
    endtask

    task automatic flags(input logic [6:0] ea, input logic [6:0] eb);
        chk("fifo status flags", {25'h0, ea}, {25'h0, st_a});
        chk("plain status flags", {25'h0, eb}, {25'h0, st_b});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status read", 32'h0000_0025, got_a);
        chk("plain status read", 32'h0000_0025, got_b);
        flags(7'h25, 7'h25);
        $display("test reset done");
    endtask

    task automatic t_regs;
        apb(1'b1, STATUS_OFFSET, 32'hffff_ffff);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status after write", 32'h0000_0025, got_a);
        chk("status error", 32'h0, {31'h0, got_err});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, got_err});
        chk("plain unmapped error", 32'h1, {31'h0, err_b});
        chk("unmapped data", 32'h0, got_a);
        apb(1'b1, CONFIG_OFFSET, 32'hffff_ffff);
        apb(1'b0, CONFIG_OFFSET, 32'h0);
        chk("config read", 32'h0000_0007, got_a);
        chk("config out", 32'h7, {29'h0, cfg_a});
        chk("plain config out", 32'h7, {29'h0, cfg_b});
        apb(1'b1, CONFIG_OFFSET, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_clock_mode;
        logic [1:0]  m;
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            e = {25'h0, m[1] ^ m[0], 6'h25};
            apb(1'b1, CONFIG_OFFSET, {29'h0, m, 1'b0});
            tick(2);
            flags(e[6:0], 7'h25);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk("clock error read", e, got_a);
        end
        apb(1'b1, CONFIG_OFFSET, 32'h0);
        tick(2);
        flags(7'h25, 7'h25);
        $display("test clock mode done");
    endtask

    task automatic t_slave_sel;
        @(posedge SYS_CLK_IN);
        evt.ss_active <= 1'b1;
        tick(1);
        flags(7'h05, 7'h05);
        chk("strobe as slave", 32'h0, {31'h0, stb_a});
        @(posedge SYS_CLK_IN);
        evt.ss_active <= 1'b0;
        tick(1);
        flags(7'h25, 7'h25);
        $display("test slave select done");
    endtask

    task automatic t_mode_fault;
        apb(1'b1, CONFIG_OFFSET, 32'h1);
        @(posedge SYS_CLK_IN);
        evt.ss_active <= 1'b1;
        tick(1);
        chk("strobe high", 32'h1, {31'h0, stb_a});
        chk("plain strobe high", 32'h1, {31'h0, stb_b});
        flags(7'h35, 7'h35);
        tick(1);
        chk("strobe one cycle", 32'h0, {31'h0, stb_a});
        flags(7'h35, 7'h35);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        #1;
        flags(7'h35, 7'h35);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("fault read", 32'h0000_0035, got_a);
        chk("plain fault read", 32'h0000_0035, got_b);
        #1;
        flags(7'h25, 7'h25);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("fault after read", 32'h0000_0025, got_a);
        @(posedge SYS_CLK_IN);
        evt.ss_active <= 1'b0;
        tick(2);
        chk("no strobe on release", 32'h0, {31'h0, stb_a});
        apb(1'b1, CONFIG_OFFSET, 32'h0);
        $display("test mode fault done");
    endtask

    // the no-fifo instance sees the same events as a one-word register
    task automatic t_fifo;
        pulse(3'b100, 1);
        flags(7'h21, 7'h29);
        pulse(3'b100, 14);
        flags(7'h21, 7'h29);
        pulse(3'b100, 1);
        flags(7'h29, 7'h29);
        pulse(3'b001, 1);
        flags(7'h20, 7'h26);
        pulse(3'b001, 14);
        flags(7'h20, 7'h26);
        pulse(3'b001, 1);
        flags(7'h26, 7'h26);
        pulse(3'b001, 1);
        flags(7'h26, 7'h26);
        pulse(3'b010, 1);
        flags(7'h24, 7'h25);
        pulse(3'b010, 15);
        flags(7'h25, 7'h25);
        $display("test fifo flags done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        RESET_IN   = 1'b1;
        psel       = 1'b0;
        pen        = 1'b0;
        pwr        = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        evt        = '0;
        n_mismatch = 0;
        cmp_count  = 0;
        repeat (10) @(posedge SYS_CLK_IN);
        RESET_IN <= 1'b0;
        t_reset();
        t_regs();
        t_clock_mode();
        t_slave_sel();
        t_mode_fault();
        t_fifo();
        finish_test();
    end

    // whole run is under two hundred cycles; this span is ample
    initial begin
        repeat (5000) @(posedge SYS_CLK_IN);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end

endmodule

`default_nettype wire
